/* ltpg_pkg.sv */
// Purpose: Constants, types and the step table of the link test pattern generator.
// Assumes: One 8-bit character per clock goes to a downstream 8b/10b encoder.
// Notes: Each rule is tagged where its logic or its check stands.
// Summary of operation
// - Low transition density sends F1 FE 27 EE FE C7, then D30.3 pairs n>12 times, then E3 FC E3 FC.
// - Half-rate high transition density repeats D21.5 (B5) more than twelve times.
// - Quarter-rate high transition density sends D24.3 (78) as a pair repeated more than twelve times.
// - High transition density follows the D24.3 pairs with D10.2 n>12 times, then D25.6/D6.1 pairs n>12 times.
// - Low-frequency content sends D11.5 n>12 times, D11.7, a run of D20.2, D20.7, then D11.5 again.
// - Simultaneous switching sends D31.3 (7F) in alternating disparity for more than 512 repetitions.
// - Non-compliant mode sends the bare character stream with no frame start, checksum or frame end.
// - Compliant mode wraps the pattern as frame payload between a start primitive and the CRC plus end primitive.
// - Compliant mode keeps inserting pairs of ALIGN primitives and never suppresses them.
// - A composite class chains low-frequency, low and high transition density classes in order.
// - Characters are encoded at the running disparity in effect, with no forced starting disparity.
// - Compliant frames are filled with the pattern up to the maximum frame payload length.
// - The far-end transmit test mode is entered when the other party sends a self-test frame.
package ltpg_pkg;

    localparam int REP_W = 16;
    localparam int PAY_W = 14;
    localparam logic [REP_W-1:0] REP_MIN_N = 16'h000D;
    localparam logic [REP_W-1:0] REP_MIN_SSO = 16'h0201;
    localparam logic [10:0] ALIGN_GAP_CHARS = 11'h400;

    // Primitive characters.
    localparam logic [7:0] CH_K28_5 = 8'hBC;
    localparam logic [7:0] CH_K28_3 = 8'h7C;
    localparam logic [7:0] CH_D10_2 = 8'h4A;
    localparam logic [7:0] CH_D27_3 = 8'h7B;
    localparam logic [7:0] CH_D23_1 = 8'h37;
    localparam logic [7:0] CH_D21_6 = 8'hD5;
    localparam logic [31:0] CRC_INIT = 32'h52325032;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;

    typedef enum logic [2:0] {
        CLS_LTD = 3'b000,
        CLS_HTD = 3'b001,
        CLS_LFSC = 3'b010,
        CLS_SSO = 3'b011,
        CLS_COMP = 3'b100
    } ltpg_class_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BARE = 3'b001,
        ST_SOF = 3'b010,
        ST_DATA = 3'b011,
        ST_CRC = 3'b100,
        ST_EOF = 3'b101,
        ST_ALIGN = 3'b110
    } ltpg_state_e;

    typedef enum logic [1:0] {
        CNT_ONE = 2'b00,
        CNT_N = 2'b01,
        CNT_SSO = 2'b10
    } ltpg_cnt_e;

    typedef struct packed {
        logic [7:0] ch_a;
        logic [7:0] ch_b;
        logic pair;
        ltpg_cnt_e cnt;
    } ltpg_step_s;

    // Step table: low-frequency 0..3, low density 4..14, high density 15..18, switching 19.
    localparam logic [4:0] IDX_LFSC = 5'h00;
    localparam logic [4:0] IDX_LFSC_END = 5'h03;
    localparam logic [4:0] IDX_LTD = 5'h04;
    localparam logic [4:0] IDX_LTD_END = 5'h0E;
    localparam logic [4:0] IDX_HTD = 5'h0F;
    localparam logic [4:0] IDX_HTD_END = 5'h12;
    localparam logic [4:0] IDX_SSO = 5'h13;

    function automatic ltpg_step_s ltpg_step(input logic [4:0] idx);
        case (idx)
            5'h00: ltpg_step = '{8'hAB, 8'hAB, 1'b0, CNT_N};
            5'h01: ltpg_step = '{8'hEB, 8'hEB, 1'b0, CNT_ONE};
            5'h02: ltpg_step = '{8'h54, 8'h54, 1'b0, CNT_N};
            5'h03: ltpg_step = '{8'hF4, 8'hF4, 1'b0, CNT_ONE};
            5'h04: ltpg_step = '{8'hF1, 8'hF1, 1'b0, CNT_ONE};
            5'h05: ltpg_step = '{8'hFE, 8'hFE, 1'b0, CNT_ONE};
            5'h06: ltpg_step = '{8'h27, 8'h27, 1'b0, CNT_ONE};
            5'h07: ltpg_step = '{8'hEE, 8'hEE, 1'b0, CNT_ONE};
            5'h08: ltpg_step = '{8'hFE, 8'hFE, 1'b0, CNT_ONE};
            5'h09: ltpg_step = '{8'hC7, 8'hC7, 1'b0, CNT_ONE};
            5'h0A: ltpg_step = '{8'h7E, 8'h7E, 1'b1, CNT_N};
            5'h0B: ltpg_step = '{8'hE3, 8'hE3, 1'b0, CNT_ONE};
            5'h0C: ltpg_step = '{8'hFC, 8'hFC, 1'b0, CNT_ONE};
            5'h0D: ltpg_step = '{8'hE3, 8'hE3, 1'b0, CNT_ONE};
            5'h0E: ltpg_step = '{8'hFC, 8'hFC, 1'b0, CNT_ONE};
            5'h0F: ltpg_step = '{8'hB5, 8'hB5, 1'b0, CNT_N};
            5'h10: ltpg_step = '{8'h78, 8'h78, 1'b1, CNT_N};
            5'h11: ltpg_step = '{8'h4A, 8'h4A, 1'b0, CNT_N};
            5'h12: ltpg_step = '{8'hD9, 8'h26, 1'b1, CNT_N};
            5'h13: ltpg_step = '{8'h7F, 8'h7F, 1'b1, CNT_SSO};
            default: ltpg_step = '{8'hAB, 8'hAB, 1'b0, CNT_N};
        endcase
    endfunction

endpackage

/* ltpg_crc.sv */
// Purpose: Frame checksum over payload bytes, updated once per assembled dword.
// Assumes: Bytes arrive low byte first; the dword is folded most significant bit first.
// Notes: The value is final one clock after the fourth byte of the last dword.
`timescale 1ns/1ps
`default_nettype none
module ltpg_crc
    import ltpg_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Byte stream.
    input wire logic init,
    input wire logic byte_en,
    input wire logic [7:0] byte_in,
    // Result.
    output logic [31:0] crc
);

    logic [23:0] part_r;
    logic [1:0] cnt_r;

    function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            part_r <= 24'h000000;
            cnt_r <= 2'h0;
            crc <= CRC_INIT;
        end else if (ce) begin
            if (init) begin
                cnt_r <= 2'h0;
                crc <= CRC_INIT;
            end else if (byte_en) begin
                cnt_r <= cnt_r + 2'h1;
                part_r <= {byte_in, part_r[23:8]};
                if (cnt_r == 2'h3) begin
                    crc <= fold(crc, {byte_in, part_r});
                end
            end
        end
    end

endmodule // ltpg_crc
`default_nettype wire

/* ltpg_gen.sv */
// Purpose: Test pattern source for the serial link transmit path.
// Assumes: The downstream encoder tracks running disparity and turns each character into ten bits.
// Notes: Stop ends the output at once, even inside a frame.
`timescale 1ns/1ps
`default_nettype none
module ltpg_gen
    import ltpg_pkg::*;
#(
    parameter logic [15:0] REP_N = 16'h0010,
    parameter logic [15:0] REP_N_FRAME = 16'h0040,
    parameter logic [15:0] REP_SSO = 16'h0208,
    parameter logic [13:0] PAYLOAD_BYTES = 14'h2000 - 14'h0001
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Control.
    input wire ltpg_pkg::ltpg_class_e class_sel,
    input wire logic compliant,
    input wire logic start,
    input wire logic stop,
    input wire logic far_tx_req,
    // Character stream.
    output logic [7:0] tx_char,
    output logic tx_is_k,
    output logic tx_valid,
    output logic busy
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ltpg_state_e st_r, st_nxt, ret_r, norm_nxt;
    ltpg_class_e cls_r;
    logic cmp_r;
    logic [2:0] sub_r;
    logic [4:0] idx_r, idx_first, idx_last;
    logic [REP_W-1:0] rep_r, rep_lim, rep_n_r, rep_nf_r, rep_sso_r;
    logic half_r;
    logic [PAY_W-1:0] pay_r;
    logic [10:0] align_cnt_r;
    logic [31:0] crc_val;
    ltpg_step_s step;
    logic [7:0] pat_ch, cur_ch;
    logic cur_k, adv, go, seq_load, dword_end, framed, go_align;

    localparam logic [REP_W-1:0] EFF_N = (REP_N < REP_MIN_N) ? REP_MIN_N : REP_N;
    localparam logic [REP_W-1:0] EFF_NF = (REP_N_FRAME < REP_MIN_N) ? REP_MIN_N : REP_N_FRAME;
    localparam logic [REP_W-1:0] EFF_SSO = (REP_SSO < REP_MIN_SSO) ? REP_MIN_SSO : REP_SSO;

    // ------------------------------------------------------------
    // Pattern sequencer
    // ------------------------------------------------------------
    assign step = ltpg_step(idx_r);
    assign pat_ch = half_r ? step.ch_b : step.ch_a;
    assign go = (start || far_tx_req) && !stop;

    always_comb begin
        idx_first = IDX_LFSC;
        idx_last = IDX_HTD_END;
        case (cls_r)
            CLS_LTD: begin
                idx_first = IDX_LTD;
                idx_last = IDX_LTD_END;
            end
            CLS_HTD: begin
                idx_first = IDX_HTD;
                idx_last = IDX_HTD_END;
            end
            CLS_LFSC: begin
                idx_first = IDX_LFSC;
                idx_last = IDX_LFSC_END;
            end
            CLS_SSO: begin
                idx_first = IDX_SSO;
                idx_last = IDX_SSO;
            end
            default: begin
                idx_first = IDX_LFSC;
                idx_last = IDX_HTD_END;
            end
        endcase
    end

    always_comb begin
        case (step.cnt)
            CNT_ONE: rep_lim = 16'h0001;
            CNT_N: rep_lim = cmp_r ? rep_nf_r : rep_n_r;
            CNT_SSO: rep_lim = rep_sso_r;
            default: rep_lim = 16'h0001;
        endcase
    end

    // Counts are reloaded from their clamped values at reset and at each start.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rep_n_r <= EFF_N;
            rep_nf_r <= EFF_NF;
            rep_sso_r <= EFF_SSO;
        end else if (ce && go && st_r == ST_IDLE) begin
            rep_n_r <= EFF_N;
            rep_nf_r <= EFF_NF;
            rep_sso_r <= EFF_SSO;
        end
    end

    assign adv = (st_r == ST_BARE || st_r == ST_DATA) && !stop;
    assign seq_load = (st_r == ST_IDLE && go) || (st_r == ST_EOF && sub_r == 3'h3);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cls_r <= CLS_LTD;
            cmp_r <= 1'b0;
        end else if (ce && st_r == ST_IDLE && go) begin
            cls_r <= far_tx_req ? class_sel : class_sel;
            cmp_r <= compliant && !far_tx_req;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idx_r <= IDX_LTD;
            rep_r <= '0;
            half_r <= 1'b0;
        end else if (ce) begin
            if (seq_load) begin
                idx_r <= (st_r == ST_IDLE) ? ((class_sel == CLS_LTD) ? IDX_LTD :
                         (class_sel == CLS_HTD) ? IDX_HTD :
                         (class_sel == CLS_SSO) ? IDX_SSO : IDX_LFSC) : idx_first;
                rep_r <= '0;
                half_r <= 1'b0;
            end else if (adv) begin
                if (step.pair && !half_r) begin
                    half_r <= 1'b1;
                end else begin
                    half_r <= 1'b0;
                    if (rep_r + 16'h0001 >= rep_lim) begin
                        rep_r <= '0;
                        idx_r <= (idx_r == idx_last) ? idx_first : idx_r + 5'h01;
                    end else begin
                        rep_r <= rep_r + 16'h0001;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Framing state machine
    // ------------------------------------------------------------
    assign framed = cmp_r && st_r != ST_IDLE && st_r != ST_BARE;
    assign dword_end = ((st_r == ST_SOF || st_r == ST_CRC || st_r == ST_EOF) && sub_r == 3'h3)
                       || (st_r == ST_DATA && pay_r[1:0] == 2'h3);
    assign go_align = framed && st_r != ST_ALIGN && dword_end
                      && align_cnt_r >= ALIGN_GAP_CHARS - 11'h001;

    always_comb begin
        norm_nxt = st_r;
        case (st_r)
            ST_IDLE: norm_nxt = go ? (compliant && !far_tx_req ? ST_SOF : ST_BARE) : ST_IDLE;
            ST_BARE: norm_nxt = ST_BARE;
            ST_SOF: norm_nxt = (sub_r == 3'h3) ? ST_DATA : ST_SOF;
            ST_DATA: norm_nxt = (pay_r == PAYLOAD_BYTES) ? ST_CRC : ST_DATA;
            ST_CRC: norm_nxt = (sub_r == 3'h3) ? ST_EOF : ST_CRC;
            ST_EOF: norm_nxt = (sub_r == 3'h3) ? ST_SOF : ST_EOF;
            ST_ALIGN: norm_nxt = (sub_r == 3'h7) ? ret_r : ST_ALIGN;
            default: norm_nxt = ST_IDLE;
        endcase
        st_nxt = stop ? ST_IDLE : (go_align ? ST_ALIGN : norm_nxt);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= ST_IDLE;
            ret_r <= ST_IDLE;
            sub_r <= 3'h0;
        end else if (ce) begin
            st_r <= st_nxt;
            if (go_align) begin
                ret_r <= norm_nxt;
            end
            sub_r <= (st_nxt != st_r) ? 3'h0 : sub_r + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pay_r <= '0;
        end else if (ce) begin
            if (st_r == ST_DATA) begin
                pay_r <= pay_r + 14'h0001;
            end else if (st_r == ST_SOF) begin
                pay_r <= '0;
            end
        end
    end

    // Characters since the last ALIGN pair; the pair goes in at the next dword edge.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            align_cnt_r <= '0;
        end else if (ce) begin
            if (st_r == ST_IDLE || st_r == ST_ALIGN) begin
                align_cnt_r <= '0;
            end else if (framed) begin
                align_cnt_r <= align_cnt_r + 11'h001;
            end
        end
    end

    ltpg_crc u_crc (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .init(st_r == ST_SOF),
        .byte_en(st_r == ST_DATA),
        .byte_in(pat_ch),
        .crc(crc_val)
    );

    // ------------------------------------------------------------
    // Character output
    // ------------------------------------------------------------
    always_comb begin
        cur_ch = pat_ch;
        cur_k = 1'b0;
        case (st_r)
            ST_SOF: begin
                cur_ch = (sub_r == 3'h0) ? CH_K28_3 : CH_D23_1;
                cur_k = (sub_r == 3'h0);
            end
            ST_CRC: cur_ch = crc_val[8*sub_r[1:0] +: 8];
            ST_EOF: begin
                cur_ch = (sub_r == 3'h0) ? CH_K28_3 : CH_D21_6;
                cur_k = (sub_r == 3'h0);
            end
            ST_ALIGN: begin
                cur_ch = (sub_r[1:0] == 2'h0) ? CH_K28_5 :
                         (sub_r[1:0] == 2'h3) ? CH_D27_3 : CH_D10_2;
                cur_k = (sub_r[1:0] == 2'h0);
            end
            default: begin
                cur_ch = pat_ch;
                cur_k = 1'b0;
            end
        endcase
    end

    // Disparity is left to the encoder, so pairs alternate naturally.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_char <= 8'h00;
            tx_is_k <= 1'b0;
            tx_valid <= 1'b0;
        end else if (ce) begin
            tx_char <= cur_ch;
            tx_is_k <= cur_k;
            tx_valid <= st_r != ST_IDLE && !stop;
        end
    end

    assign busy = st_r != ST_IDLE;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_bare_no_k: assert property (ce && st_r == ST_BARE && !stop |=> tx_valid && !tx_is_k)
        else $error("bare stream carried a control character");
    a_ltd_lead_in: assert property (ce && adv && idx_r == 5'h04 |=> tx_char == 8'hF1)
        else $error("low density lead-in is not F1");
    a_htd_half: assert property (ce && adv && idx_r == IDX_HTD |=> tx_char == 8'hB5)
        else $error("half-rate character is not B5");
    a_htd_tail: assert property (ce && adv && idx_r == 5'h12 && half_r |=> tx_char == 8'h26)
        else $error("second half of the pair is not 26");
    a_lfsc_order: assert property (ce && adv && idx_r == 5'h01 |=> tx_char == 8'hEB)
        else $error("low frequency marker is not EB");
    a_sso_count: assert property (step.cnt == CNT_SSO |-> rep_lim > 16'h0200)
        else $error("switching run too short");
    a_rep_floor: assert property (cmp_r |-> rep_nf_r >= REP_MIN_N && rep_n_r >= REP_MIN_N)
        else $error("repetition count below minimum");
    a_align_pair: assert property (ce && st_r == ST_ALIGN && sub_r == 3'h4
                                   |=> tx_char == CH_K28_5 && tx_is_k)
        else $error("second ALIGN missing");
    a_align_gap: assert property (framed |-> align_cnt_r < ALIGN_GAP_CHARS + 11'h004)
        else $error("ALIGN insertion overdue");
    a_sof_lead: assert property (ce && st_r == ST_SOF && sub_r == 3'h0 && !stop
                                 |=> tx_char == CH_K28_3 && tx_is_k)
        else $error("frame does not open with start primitive");
    a_crc_follows: assert property (ce && st_r == ST_DATA && pay_r == PAYLOAD_BYTES && !stop
                                    |=> st_r == ST_CRC || st_r == ST_ALIGN)
        else $error("payload not followed by checksum");

    c_sso_run: cover property (ce && st_r == ST_BARE && cls_r == CLS_SSO);
    c_frame_done: cover property (ce && st_r == ST_EOF && sub_r == 3'h3);
    c_align_burst: cover property (ce && st_r == ST_ALIGN && sub_r == 3'h7);

endmodule // ltpg_gen
`default_nettype wire

/* ltpg_rx_model.sv */
// Purpose: Receiver-side model that records the character stream and can request a self-test run.
// Assumes: A character is taken at each rising clock edge while tx_valid and ce are high.
// Notes: The one-cycle request stands for a self-test frame that has just been received.
`timescale 1ns/1ps
`default_nettype none
module ltpg_rx_model (
    // Clock.
    input wire logic clk,
    input wire logic ce,
    // Character stream.
    input wire logic [7:0] tx_char,
    input wire logic tx_is_k,
    input wire logic tx_valid,
    // Self-test request.
    output logic far_tx_req
);
    logic [8:0] rxq[$];

    initial begin
        far_tx_req = 1'b0;
    end

    always @(posedge clk) begin
        if (tx_valid === 1'b1 && ce === 1'b1) begin
            rxq.push_back({tx_is_k, tx_char});
        end
    end

    task automatic send_selftest();
        @(posedge clk);
        far_tx_req <= 1'b1;
        @(posedge clk);
        far_tx_req <= 1'b0;
    endtask
endmodule // ltpg_rx_model
`default_nettype wire

/* link_test_pattern_generator_tb.sv */
// Purpose: Self-checking bench for the link test pattern generator.
// Assumes: Counts are shortened to their minimum, except REP_N_FRAME at 14; the frame payload is 64 bytes.
// Notes: Checksum bytes are compared against a bench model of the frame checksum.
`timescale 1ns/1ps
`default_nettype none
module link_test_pattern_generator_tb;
    import ltpg_pkg::*;
    localparam logic [15:0] N = 16'h000D;
    localparam logic [15:0] NF = 16'h000E;
    localparam logic [15:0] NS = 16'h0201;
    localparam logic [13:0] PB = 14'h003F;
    logic clk, reset, ce, compliant, start, stop, far_tx_req;
    ltpg_class_e class_sel;
    logic [7:0] tx_char;
    logic tx_is_k, tx_valid, busy;
    int mismatches, checks;
    logic [8:0] exp_q[$];

    // REP_N is set below its floor, so the bare runs must show the clamped count.
    ltpg_gen #(.REP_N(16'h0004), .REP_N_FRAME(NF),
        .REP_SSO(NS), .PAYLOAD_BYTES(PB)) dut (
        .clk(clk), .reset(reset), .ce(ce), .class_sel(class_sel), .compliant(compliant),
        .start(start), .stop(stop), .far_tx_req(far_tx_req), .tx_char(tx_char),
        .tx_is_k(tx_is_k), .tx_valid(tx_valid), .busy(busy));

    ltpg_rx_model rx (.clk(clk), .ce(ce), .tx_char(tx_char), .tx_is_k(tx_is_k),
        .tx_valid(tx_valid), .far_tx_req(far_tx_req));

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic put(input logic k, input logic [7:0] ch, input int n);
        repeat (n) exp_q.push_back({k, ch});
    endtask

    // Frame checksum over n payload bytes of exp_q from index lo, low byte first per dword.
    function automatic logic [31:0] crc_of(input int lo, input int n);
        logic [31:0] c;
        logic [31:0] w;
        c = CRC_INIT;
        for (int j = 0; j < n; j += 4) begin
            w = {exp_q[lo+j+3][7:0], exp_q[lo+j+2][7:0], exp_q[lo+j+1][7:0], exp_q[lo+j][7:0]};
            for (int b = 31; b >= 0; b--) begin
                c = (c[31] ^ w[b]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
            end
        end
        return c;
    endfunction

    task automatic add_ltd(input int n);
        put(0, 8'hF1, 1); put(0, 8'hFE, 1); put(0, 8'h27, 1);
        put(0, 8'hEE, 1); put(0, 8'hFE, 1); put(0, 8'hC7, 1);
        put(0, 8'h7E, 2 * n);
        put(0, 8'hE3, 1); put(0, 8'hFC, 1); put(0, 8'hE3, 1); put(0, 8'hFC, 1);
    endtask

    task automatic add_htd();
        put(0, 8'hB5, N);
        put(0, 8'h78, 2 * N);
        put(0, 8'h4A, N);
        repeat (N) begin
            put(0, 8'hD9, 1);
            put(0, 8'h26, 1);
        end
    endtask

    task automatic add_lfsc();
        put(0, 8'hAB, N); put(0, 8'hEB, 1); put(0, 8'h54, N); put(0, 8'hF4, 1);
    endtask

    task automatic begin_run(input ltpg_class_e cls, input logic comp);
        @(posedge clk);
        rx.rxq.delete();
        class_sel <= cls;
        compliant <= comp;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask

    task automatic wait_chars(input int n);
        int k;
        for (k = 0; k < n + 100 && rx.rxq.size() < n; k++) @(posedge clk);
        if (rx.rxq.size() < n) begin
            mismatches++;
            $display("ERROR t=%0t timeout got=%h exp=%h", $time, rx.rxq.size(), n);
            tally_and_finish();
        end
    endtask

    // Compares the received stream with exp_q, skipping positions lo..hi.
    task automatic match(input int lo, input int hi);
        wait_chars(exp_q.size());
        foreach (exp_q[i]) if (i < lo || i > hi) chk(rx.rxq[i], exp_q[i]);
    endtask

    task automatic end_run(input string name);
        @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        @(negedge clk);
        chk({busy, tx_valid, 7'h00}, 9'h000);
        exp_q.delete();
        $display("%s done", name);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_ltd();
        add_ltd(N); add_ltd(N);
        begin_run(CLS_LTD, 1'b0);
        match(-1, -1);
        end_run("test_ltd");
    endtask

    task automatic test_htd();
        add_htd(); add_htd();
        begin_run(CLS_HTD, 1'b0);
        match(-1, -1);
        end_run("test_htd");
    endtask

    task automatic test_lfsc();
        add_lfsc(); add_lfsc(); add_lfsc();
        begin_run(CLS_LFSC, 1'b0);
        match(-1, -1);
        end_run("test_lfsc");
    endtask

    task automatic test_sso();
        put(0, 8'h7F, 2 * NS + 2);
        begin_run(CLS_SSO, 1'b0);
        match(-1, -1);
        end_run("test_sso");
    endtask

    task automatic test_comp();
        add_lfsc(); add_ltd(N); add_htd(); add_lfsc();
        begin_run(CLS_COMP, 1'b0);
        match(-1, -1);
        end_run("test_comp");
    endtask

    task automatic test_framed();
        logic [31:0] crc;
        put(1, 8'h7C, 1); put(0, 8'h37, 3);
        add_ltd(NF); add_ltd(NF);
        while (exp_q.size() > 4 + PB + 1) exp_q.pop_back();
        crc = crc_of(4, PB + 1);
        for (int j = 0; j < 4; j++) put(0, crc[8*j +: 8], 1);
        put(1, 8'h7C, 1); put(0, 8'hD5, 3);
        put(1, 8'h7C, 1); put(0, 8'h37, 3);
        begin_run(CLS_LTD, 1'b1);
        match(-1, -1);
        end_run("test_framed");
    endtask

    task automatic test_align();
        int found;
        logic hit;
        found = -1;
        put(1, 8'hBC, 1); put(0, 8'h4A, 2); put(0, 8'h7B, 1);
        put(1, 8'hBC, 1); put(0, 8'h4A, 2); put(0, 8'h7B, 1);
        begin_run(CLS_SSO, 1'b1);
        wait_chars(1300);
        for (int i = 0; i < 1290 && found < 0; i++) begin
            hit = 1'b1;
            for (int j = 0; j < 8; j++) begin
                if (rx.rxq[i+j] !== exp_q[j]) hit = 1'b0;
            end
            if (hit) found = i;
        end
        chk({found >= 1024, found <= 1104, found[1:0], 5'h00}, 9'h180);
        end_run("test_align");
    endtask

    task automatic test_far();
        add_ltd(N);
        @(posedge clk);
        rx.rxq.delete();
        class_sel <= CLS_LTD;
        compliant <= 1'b1;
        rx.send_selftest();
        match(-1, -1);
        end_run("test_far");
    endtask

    // Clock enable low must hold the character and the sequence without a skip.
    task automatic test_hold();
        logic [8:0] held;
        add_ltd(N);
        begin_run(CLS_LTD, 1'b0);
        repeat (5) @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        held = {tx_is_k, tx_char};
        repeat (4) @(negedge clk);
        chk({tx_is_k, tx_char}, held);
        chk({busy, tx_valid, 7'h00}, 9'h180);
        @(posedge clk);
        ce <= 1'b1;
        match(-1, -1);
        end_run("test_hold");
    endtask

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        ce = 1'b1;
        class_sel = CLS_LTD;
        compliant = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        mismatches = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        test_ltd();
        test_htd();
        test_lfsc();
        test_sso();
        test_comp();
        test_framed();
        test_align();
        test_far();
        test_hold();
        tally_and_finish();
    end
endmodule // link_test_pattern_generator_tb
`default_nettype wire
